// [raee_pkg.sv]
// ==========================================================
// constants and carriers for reset and exception entry
// ==========================================================
package raee_pkg;

  // register word offsets (byte address = offset)
  localparam logic [7:0] RAEE_OFS_PSW = 8'h00;
  localparam logic [7:0] RAEE_OFS_EPSW = 8'h04;
  localparam logic [7:0] RAEE_OFS_VBASE = 8'h08;
  localparam logic [7:0] RAEE_OFS_STATUS = 8'h0c;
  localparam logic [7:0] RAEE_OFS_CTRL = 8'h10;

  // field positions
  localparam int RAEE_CTRL_RTE_BIT = 0;
  localparam int RAEE_VBASE_LSB = 12;
  localparam int RAEE_ST_SEQ_LSB = 0;
  localparam int RAEE_ST_PEND_LSB = 5;
  localparam int RAEE_ST_VEC_LSB = 11;
  localparam int RAEE_ST_SHADOW_BIT = 20;

  // fixed vector numbers
  localparam logic [8:0] RAEE_VEC_RESET = 9'h000;
  localparam logic [8:0] RAEE_VEC_INT = 9'h001;
  localparam logic [8:0] RAEE_VEC_DATA = 9'h003;
  localparam logic [8:0] RAEE_VEC_OVF = 9'h009;
  localparam logic [8:0] RAEE_VEC_FP_IMP = 9'h073;

  // reset vector fetch address
  localparam logic [31:0] RAEE_RESET_ADDR = 32'h0000_0000;

  // pending source indices, highest priority first
  localparam int RAEE_NSRC = 6;
  localparam int RAEE_SRC_IERR = 0;
  localparam int RAEE_SRC_OVF = 1;
  localparam int RAEE_SRC_TRAP = 2;
  localparam int RAEE_SRC_INT = 3;
  localparam int RAEE_SRC_FP = 4;
  localparam int RAEE_SRC_DATA = 5;

  // reset sequencer, one-hot
  typedef enum logic [4:0] {
    RAEE_SEQ_QUIET = 5'h01,
    RAEE_SEQ_FETCH0 = 5'h02,
    RAEE_SEQ_RUN = 5'h04,
    RAEE_SEQ_DRAIN = 5'h08,
    RAEE_SEQ_VECTOR = 5'h10
  } raee_seq_t;

  // processor status word, bit 0 is the shadow freeze flag
  typedef struct packed {
    logic supervisor;
    logic fp_freeze;
    logic int_dis;
    logic shadow_freeze;
  } raee_psw_t;

  localparam raee_psw_t RAEE_PSW_RST = 4'hf;

  // exception event inputs from the execution units
  typedef struct packed {
    logic ierr;
    logic [8:0] ierr_num;
    logic ovf;
    logic trap;
    logic [8:0] trap_num;
    logic fp_imp;
    logic data_fault;
  } raee_evt_t;

  // complete state of the block
  typedef struct packed {
    raee_seq_t seq;
    logic [2:0] int_sync;
    logic int_level;
    logic [RAEE_NSRC-1:0] pend;
    logic [8:0] ierr_num;
    logic [8:0] trap_num;
    logic [8:0] vec_num;
    logic [31:0] vbase;
    raee_psw_t psw;
    raee_psw_t epsw;
    logic shadow_en;
    logic err_val;
    logic err_oe;
    logic ibus_oe;
    logic ibus_req;
    logic [31:0] ibus_addr;
    logic dbus_oe;
    logic dbus_req;
    logic branch;
    logic ack;
    logic [31:0] rdat;
  } raee_state_t;

  localparam raee_state_t RAEE_STATE_RST = '{
    seq: RAEE_SEQ_QUIET,
    psw: RAEE_PSW_RST,
    epsw: RAEE_PSW_RST,
    err_oe: 1'b1,
    default: '0
  };

endpackage

// [raee_top.sv]
`timescale 1ns/1ps
module raee_top
  import raee_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic int_pin,
  input wire raee_evt_t evt_i,
  input wire logic insn_boundary,
  input wire logic data_pending,
  input wire logic data_access_req,
  input wire logic fetch_req,
  input wire logic [31:0] fetch_addr,
  input wire logic err_raise,
  output logic err_o,
  output logic err_oe,
  output logic ibus_oe,
  output logic ibus_req,
  output logic [31:0] ibus_addr,
  output logic dbus_oe,
  output logic dbus_req,
  output logic branch_taken,
  output logic shadow_en,
  output logic supervisor,
  output logic int_dis,
  output logic fp_freeze
);

  // ==========================================================
  // helpers
  // ==========================================================

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] raee_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // index of the highest-priority pending source
  function automatic logic [2:0] raee_pick(input logic [RAEE_NSRC-1:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = RAEE_NSRC - 1; i >= 0; i--) begin
      if (p[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ==========================================================
  // state
  // ==========================================================
  raee_state_t st_ff;
  raee_state_t nxt_st;

  logic wb_req;
  logic wb_wr;
  logic [RAEE_NSRC-1:0] src_evt;
  logic [RAEE_NSRC-1:0] src_clr;
  logic [2:0] pick;
  logic take_exc;
  logic [8:0] pick_num;
  logic [31:0] psw_merged;
  logic [31:0] vbase_merged;

  // ==========================================================
  // limitations and trade-offs
  // ==========================================================
  // the status word is only four bits wide here; upper write data is
  // dropped on purpose, so software reading it back sees zeros above
  // bit 3. the vector base keeps only its top 20 bits, because the
  // handler address concatenates them with the vector number and the
  // low twelve bits could never reach the fetch address anyway.
  // the interrupt pending bit is a level, not a latch: a pin that
  // drops before a boundary loses its request, which matches a
  // level-sensitive request line and avoids a stale entry after the
  // source has been serviced by other means.
  // a store to the status word in the same cycle as an entry loses
  // to the entry, so a frozen context can never be unfrozen by a
  // racing store.

  // a write commits on the edge where the master sees ack
  assign wb_req = wb_cyc_i && wb_stb_i;
  assign wb_wr = wb_req && wb_we_i && st_ff.ack;

  // byte-lane merges, cut to the register width below
  assign psw_merged = raee_merge({28'h0, st_ff.psw}, wb_dat_i, wb_sel_i);
  assign vbase_merged = raee_merge(st_ff.vbase, wb_dat_i, wb_sel_i);

  // ==========================================================
  // next-state logic
  // ==========================================================
  always_comb begin
    nxt_st = st_ff;
    src_evt = '0;
    src_clr = '0;
    pick = raee_pick(st_ff.pend);
    pick_num = RAEE_VEC_RESET;

    // three-stage pin sync; level moves when stages two and three agree
    nxt_st.int_sync = {st_ff.int_sync[1:0], int_pin};
    if (st_ff.int_sync[1] == st_ff.int_sync[2]) begin
      nxt_st.int_level = st_ff.int_sync[2];
    end

    // sources: unit-detected errors, overflow, traps, pin, float_unit, bus fault
    src_evt[RAEE_SRC_IERR] = evt_i.ierr;
    src_evt[RAEE_SRC_OVF] = evt_i.ovf;
    src_evt[RAEE_SRC_TRAP] = evt_i.trap;
    src_evt[RAEE_SRC_FP] = evt_i.fp_imp;
    src_evt[RAEE_SRC_DATA] = evt_i.data_fault;
    if (evt_i.ierr) begin
      nxt_st.ierr_num = evt_i.ierr_num;
    end
    if (evt_i.trap) begin
      nxt_st.trap_num = evt_i.trap_num;
    end

    unique case (pick)
      3'(RAEE_SRC_IERR): pick_num = st_ff.ierr_num;
      3'(RAEE_SRC_OVF): pick_num = RAEE_VEC_OVF;
      3'(RAEE_SRC_TRAP): pick_num = st_ff.trap_num;
      3'(RAEE_SRC_INT): pick_num = RAEE_VEC_INT;
      3'(RAEE_SRC_FP): pick_num = RAEE_VEC_FP_IMP;
      default: pick_num = RAEE_VEC_DATA;
    endcase

    // boundary only, and never while context is frozen
    take_exc = (st_ff.seq == RAEE_SEQ_RUN) && insn_boundary && (|st_ff.pend)
      && !st_ff.psw.shadow_freeze;

    // software writes first, so hardware entry below overrides them
    if (wb_wr) begin
      unique case (wb_adr_i)
        RAEE_OFS_PSW: begin
          // only the four status bits exist, the rest is dropped
          nxt_st.psw = psw_merged[3:0];
        end
        RAEE_OFS_VBASE: begin
          // low twelve bits always read back as zero
          nxt_st.vbase = vbase_merged & {20'hfffff, 12'h000};
        end
        RAEE_OFS_CTRL: begin
          // return from exception restores saved word with freeze clear
          if (wb_sel_i[0] && wb_dat_i[RAEE_CTRL_RTE_BIT]) begin
            nxt_st.psw = st_ff.epsw;
            nxt_st.psw.shadow_freeze = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    nxt_st.branch = 1'b0;
    nxt_st.dbus_req = 1'b0;
    nxt_st.ibus_req = 1'b0;

    // reset sequencer and exception entry
    unique case (st_ff.seq)
      RAEE_SEQ_QUIET: begin
        // one more released clock so responders see a null cycle
        nxt_st.seq = RAEE_SEQ_FETCH0;
      end
      RAEE_SEQ_FETCH0: begin
        nxt_st.ibus_oe = 1'b1;
        nxt_st.dbus_oe = 1'b1;
        nxt_st.ibus_req = 1'b1;
        nxt_st.ibus_addr = RAEE_RESET_ADDR;
        nxt_st.seq = RAEE_SEQ_RUN;
      end
      RAEE_SEQ_RUN: begin
        nxt_st.ibus_req = fetch_req;
        nxt_st.ibus_addr = fetch_addr;
        nxt_st.dbus_req = data_access_req;
        nxt_st.err_val = err_raise;
        if (take_exc) begin
          nxt_st.epsw = st_ff.psw;
          nxt_st.psw = RAEE_PSW_RST;
          nxt_st.vec_num = pick_num;
          src_clr[pick] = 1'b1;
          nxt_st.ibus_req = 1'b0;
          nxt_st.dbus_req = 1'b0;
          nxt_st.seq = RAEE_SEQ_DRAIN;
        end
      end
      RAEE_SEQ_DRAIN: begin
        // let the data side finish what is in flight
        if (!data_pending) begin
          nxt_st.seq = RAEE_SEQ_VECTOR;
        end
      end
      RAEE_SEQ_VECTOR: begin
        nxt_st.ibus_req = 1'b1;
        nxt_st.branch = 1'b1;
        nxt_st.ibus_addr = {st_ff.vbase[31:RAEE_VBASE_LSB], st_ff.vec_num, 3'h0};
        nxt_st.seq = RAEE_SEQ_RUN;
      end
      default: nxt_st.seq = RAEE_SEQ_QUIET;
    endcase

    // sticky pending, a new event beats a same-cycle clear
    for (int i = 0; i < RAEE_NSRC; i++) begin
      nxt_st.pend[i] = (st_ff.pend[i] & ~src_clr[i]) | src_evt[i];
    end
    // interrupt follows the pin level while enabled
    nxt_st.pend[RAEE_SRC_INT] = nxt_st.int_level & ~nxt_st.psw.int_dis;

    // shadow copies run only while the freeze flag is clear
    nxt_st.shadow_en = ~nxt_st.psw.shadow_freeze;

    // wishbone: one wait-state answer, ack drops the cycle after
    nxt_st.ack = wb_req && !st_ff.ack;
    nxt_st.rdat = 32'h0;
    if (wb_req && !st_ff.ack && !wb_we_i) begin
      unique case (wb_adr_i)
        RAEE_OFS_PSW: nxt_st.rdat = {28'h0, st_ff.psw};
        RAEE_OFS_EPSW: nxt_st.rdat = {28'h0, st_ff.epsw};
        RAEE_OFS_VBASE: nxt_st.rdat = st_ff.vbase;
        RAEE_OFS_STATUS: begin
          nxt_st.rdat[RAEE_ST_SEQ_LSB +: 5] = st_ff.seq;
          nxt_st.rdat[RAEE_ST_PEND_LSB +: RAEE_NSRC] = st_ff.pend;
          nxt_st.rdat[RAEE_ST_VEC_LSB +: 9] = st_ff.vec_num;
          nxt_st.rdat[RAEE_ST_SHADOW_BIT] = st_ff.shadow_en;
        end
        default: nxt_st.rdat = 32'h0;
      endcase
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  // every reset, cold or warm, lands in one identical state
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= RAEE_STATE_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs, all straight from the state register
  // ==========================================================
  assign wb_dat_o = st_ff.rdat;
  assign wb_ack_o = st_ff.ack;
  assign err_o = st_ff.err_val;
  assign err_oe = st_ff.err_oe; // held driven even in reset
  assign ibus_oe = st_ff.ibus_oe;
  assign ibus_req = st_ff.ibus_req;
  assign ibus_addr = st_ff.ibus_addr;
  assign dbus_oe = st_ff.dbus_oe;
  assign dbus_req = st_ff.dbus_req;
  assign branch_taken = st_ff.branch;
  assign shadow_en = st_ff.shadow_en;
  assign supervisor = st_ff.psw.supervisor;
  assign int_dis = st_ff.psw.int_dis;
  assign fp_freeze = st_ff.psw.fp_freeze;

endmodule

// [raee_asserts.sv]
`timescale 1ns/1ps
// ====
// port checker for reset and exception entry
module raee_chk
  import raee_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic data_access_req,
  input wire logic err_oe,
  input wire logic ibus_oe,
  input wire logic ibus_req,
  input wire logic [31:0] ibus_addr,
  input wire logic dbus_oe,
  input wire logic dbus_req,
  input wire logic branch_taken,
  input wire logic shadow_en,
  input wire logic supervisor,
  input wire logic int_dis,
  input wire logic fp_freeze
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // quiet clock, then the reset vector fetch
  quiet_seq_a: assert property ($rose(rst_n) |-> !ibus_oe ##1 !ibus_oe && !dbus_oe
    ##1 ibus_req && ibus_oe && ibus_addr == 32'h0) else $error("first fetch after reset wrong");
  err_drive_a: assert property (err_oe) else $error("error pin released");
  dbus_cause_a: assert property (dbus_req |-> $past(data_access_req) && dbus_oe)
    else $error("data access without request");
  ibus_enable_a: assert property (ibus_req |-> ibus_oe) else $error("fetch while released");
  entry_psw_a: assert property (branch_taken |-> supervisor && int_dis && fp_freeze && !shadow_en)
    else $error("status not frozen at vector");
  vector_align_a: assert property (branch_taken |-> ibus_req && ibus_addr[2:0] == 3'h0)
    else $error("handler address misaligned");
  no_reentry_a: assert property (branch_taken ##1 (!shadow_en)[*4] |-> !branch_taken)
    else $error("second entry while frozen");
  // shadowing only comes back through a software store
  shadow_sw_a: assert property ($rose(shadow_en) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
    else $error("shadowing enabled without store");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
endmodule

bind raee_top raee_chk u_chk (.clk, .rst_n, .wb_we_i, .wb_ack_o, .data_access_req, .err_oe, .ibus_oe, .ibus_req,
  .ibus_addr, .dbus_oe, .dbus_req, .branch_taken, .shadow_en, .supervisor, .int_dis, .fp_freeze);

// [raee_mem_model.sv]
`timescale 1ns/1ps
// ====
// cache_mem_unit stand-in on both buses
module raee_mem_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ibus_oe,
  input wire logic ibus_req,
  input wire logic [31:0] ibus_addr,
  input wire logic dbus_oe,
  input wire logic dbus_req,
  output logic [31:0] first_addr,
  output logic [7:0] dbus_cnt
);
  logic quiet_ff;
  logic seen_ff;
  // one unit per bus, never replies fault, no lock path
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_ff <= 1'b1;
      seen_ff <= 1'b0;
      first_addr <= 32'hffff_ffff; // a missing fetch shows as a mismatch
      dbus_cnt <= 8'h00;
    end else begin
      // masks the quiet clock like external glue on a direct memory
      quiet_ff <= 1'b0; // bus ignored for the clock after reset
      if (!quiet_ff && ibus_oe && ibus_req && !seen_ff) begin
        first_addr <= ibus_addr; // address latched at transfer start
        seen_ff <= 1'b1;
      end
      if (!quiet_ff && dbus_oe && dbus_req) begin
        dbus_cnt <= dbus_cnt + 8'h01;
      end
    end
  end
endmodule

// [tb_top.sv]
`timescale 1ns/1ps
// ====
// bench for reset and exception entry
module tb_top;
  import raee_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic int_pin = 1'b0, insn_boundary = 1'b0, data_pending = 1'b0, data_access_req = 1'b0;
  raee_evt_t evt_i = '0;
  logic [31:0] wb_dat_o, ibus_addr, first_addr;
  logic wb_ack_o, err_o, err_oe, ibus_oe, ibus_req, dbus_oe, dbus_req;
  logic branch_taken, shadow_en, supervisor, int_dis, fp_freeze;
  logic [7:0] dbus_cnt;
  int num_errors = 0;
  int check_count = 0;
  always #10 clk = ~clk;
  // fetch path and error value left constant, entry logic is the target
  raee_top DUT (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .int_pin, .evt_i, .insn_boundary, .data_pending, .data_access_req, .fetch_req(1'b0),
    .fetch_addr(32'h0), .err_raise(1'b0), .err_o, .err_oe, .ibus_oe, .ibus_req, .ibus_addr, .dbus_oe,
    .dbus_req, .branch_taken, .shadow_en, .supervisor, .int_dis, .fp_freeze);
  raee_mem_model MEM (.clk, .rst_n, .ibus_oe, .ibus_req, .ibus_addr, .dbus_oe, .dbus_req, .first_addr, .dbus_cnt);
  // ====
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // request held until ack is sampled, then released
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1) num_errors++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic no_branch(input int n);
    repeat (n) begin
      @(posedge clk);
      chk(32'(branch_taken), 32'h0);
    end
  endtask
  task automatic do_reset(input int cyc);
    logic [31:0] q;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (cyc) @(posedge clk);
    chk(32'({err_oe, err_o, ibus_oe, dbus_oe, ibus_req, dbus_req}), 32'h20);
    rst_n <= 1'b1; // released on a clock edge
    repeat (4) @(posedge clk);
    chk(first_addr, RAEE_RESET_ADDR);
    wb(1'b0, RAEE_OFS_PSW, 32'h0, q);
    chk(q, 32'h0000_000f);
    wb(1'b0, RAEE_OFS_VBASE, 32'h0, q);
    chk(q, 32'h0);
  endtask
  // ====
  // main sequence
  initial begin
    logic [31:0] q, vb;
    logic [8:0] num, vec;
    raee_evt_t e;
    int n;
    q = $urandom(32'h160d);
    do_reset(4);
    wb(1'b0, 8'hfc, 32'h0, q);
    chk(q, 32'h0);
    vb = $urandom();
    wb(1'b1, RAEE_OFS_VBASE, vb, q);
    vb[11:0] = 12'h000;
    wb(1'b0, RAEE_OFS_VBASE, 32'h0, q);
    chk(q, vb);
    @(posedge clk);
    data_access_req <= 1'b1;
    @(posedge clk);
    data_access_req <= 1'b0;
    repeat (3) @(posedge clk);
    chk(32'(dbus_cnt), 32'h1);
    // each source raised while frozen, then freed, boundary and drain gated
    for (int k = 0; k < 6; k++) begin
      e = '0;
      num = 9'($urandom());
      case (k)
        0: begin e.ierr = 1'b1; e.ierr_num = num; vec = num; end
        1: begin e.ovf = 1'b1; e.trap = 1'b1; e.trap_num = num; vec = RAEE_VEC_OVF; end
        2: begin e.trap = 1'b1; e.trap_num = num; vec = num; end
        3: vec = RAEE_VEC_INT;
        4: begin e.fp_imp = 1'b1; vec = RAEE_VEC_FP_IMP; end
        default: begin e.data_fault = 1'b1; vec = RAEE_VEC_DATA; end
      endcase
      @(posedge clk);
      evt_i <= e;
      int_pin <= (k == 3);
      data_pending <= 1'b1;
      insn_boundary <= 1'b1;
      @(posedge clk);
      evt_i <= '0;
      no_branch(5);
      insn_boundary <= 1'b0;
      wb(1'b1, RAEE_OFS_PSW, 32'h0, q);
      no_branch(4);
      insn_boundary <= 1'b1;
      no_branch(3);
      data_pending <= 1'b0;
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (branch_taken !== 1'b1 && n < 20);
      chk(ibus_addr, {vb[31:12], vec, 3'h0});
      chk(32'({supervisor, int_dis, fp_freeze, shadow_en}), 32'he);
      int_pin <= 1'b0;
      insn_boundary <= 1'b0;
      wb(1'b0, RAEE_OFS_EPSW, 32'h0, q);
      chk(q, 32'h0);
    end
    do_reset(8); // warm reset, held twice as long as the first
    tally_and_finish;
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    tally_and_finish;
  end
endmodule
